// ==== sepcp_core.sv ====
// Purpose: Command decode, write latch, status and page programming of an SPI EEPROM slave
// Assumes: Array outside, read combinationally from mem_addr; sck far slower than mclk
// Notes: SPI modes 0 and 3; hold pause not supported
`timescale 1ns/1ps
module sepcp_core
  import sepcp_pkg::*;
#(
  parameter int WCYC = WRITE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // SPI pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe_n,
  // Array port
  output logic [ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  input wire logic [7:0] mem_rdata,
  // Status view
  output logic [7:0] status_protect_reg
);
  localparam int NPG = 1 << PAGE_W;

  if (WCYC < MIN_WRITE_CYCLES) begin : g_bad_wcyc
    $error("WCYC too short to sweep a page");
  end

  typedef struct packed {
    sepcp_state_t state;
    logic [2:0] bitcnt;
    logic [7:0] in_sr;
    logic [7:0] out_sr;
    logic so;
    logic oe_n;
    logic is_wr;
    logic [ADDR_W-1:0] addr;
    logic [NPG-1:0][7:0] pbuf;
    logic [NPG-1:0] pvalid;
    logic write_latch_flag;
    logic block_protect_high;
    logic block_protect_low;
    logic hw_protect_enable;
    logic [7:0] wsr;
    logic wsr_ok;
    logic pend_set;
    logic pend_clr;
    logic sweep;
    logic [PAGE_W-1:0] idx;
    logic [ADDR_W-1:0] maddr;
    logic [7:0] mwdata;
    logic mwe;
    logic sck_d;
    logic cs_d;
    logic busy_d;
  } sepcp_core_t;

  sepcp_core_t st;
  sepcp_core_t next_st;
  sepcp_prog_if prog ();

  logic cs_s;
  logic sck_s;
  logic si_s;
  logic wp_s;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic hw_prot;
  logic set_ev;
  logic wsr_ev;
  logic page_ev;
  logic prog_done;
  logic [7:0] in_byte;
  logic [7:0] status_val;
  logic [1:0] bp;

  // Every pin, select and clock included, is treated as asynchronous
  sepcp_sync #(.RST_VAL(1'b1)) u_sync_cs (.mclk(mclk), .rst_n(rst_n), .pin(cs_n), .level(cs_s));
  sepcp_sync #(.RST_VAL(1'b0)) u_sync_sck (.mclk(mclk), .rst_n(rst_n), .pin(sck), .level(sck_s));
  sepcp_sync #(.RST_VAL(1'b0)) u_sync_si (.mclk(mclk), .rst_n(rst_n), .pin(si), .level(si_s));
  sepcp_sync #(.RST_VAL(1'b1)) u_sync_wp (.mclk(mclk), .rst_n(rst_n), .pin(wp_n), .level(wp_s));

  sepcp_wtimer #(.WCYC(WCYC)) u_wtimer (.mclk(mclk), .rst_n(rst_n), .p(prog.timer));

  assign cs_rise = cs_s & ~st.cs_d;
  assign cs_fall = ~cs_s & st.cs_d;
  assign sck_rise = sck_s & ~st.sck_d & ~cs_s;
  assign sck_fall = ~sck_s & st.sck_d & ~cs_s;
  assign in_byte = {st.in_sr[6:0], si_s};
  assign bp = {st.block_protect_high, st.block_protect_low};
  assign hw_prot = st.hw_protect_enable & ~wp_s;
  assign status_val = {st.hw_protect_enable, 3'h0, bp, st.write_latch_flag, prog.busy};
  // A whole number of bytes is required at select rise for page and status writes, which are otherwise dropped; latch commands ignore stray bits
  assign set_ev = cs_rise && st.state == S_WAITCS && st.pend_set;
  assign page_ev = cs_rise && st.state == S_WDATA && st.bitcnt == 3'h0 && (|st.pvalid)
                   && st.write_latch_flag && !prog.busy;
  assign wsr_ev = cs_rise && st.state == S_WSTAT && st.wsr_ok && st.bitcnt == 3'h0
                  && st.write_latch_flag && !hw_prot && !prog.busy;
  assign prog_done = st.busy_d & ~prog.busy;
  assign prog.start = page_ev | wsr_ev;

  always_comb begin
    next_st = st;
    next_st.sck_d = sck_s;
    next_st.cs_d = cs_s;
    next_st.busy_d = prog.busy;
    next_st.mwe = 1'b0;
    // The buffered page is pushed to the array one byte per cycle
    if (st.sweep) begin
      next_st.idx = st.idx + PAGE_W'(1);
      if (st.pvalid[st.idx] && !sepcp_is_prot(bp, {st.addr[ADDR_W-1:PAGE_W], st.idx})) begin
        next_st.mwe = 1'b1;
        next_st.maddr = {st.addr[ADDR_W-1:PAGE_W], st.idx};
        next_st.mwdata = st.pbuf[st.idx];
      end
      if (st.idx == PAGE_W'(NPG - 1)) begin
        next_st.sweep = 1'b0;
      end
    end else begin
      next_st.maddr = st.addr;
    end
    if (prog_done) begin
      next_st.write_latch_flag = 1'b0;
    end
    if (cs_rise) begin
      if (set_ev) begin
        next_st.write_latch_flag = 1'b1;
      end
      if (st.state == S_WAITCS && st.pend_clr) begin
        next_st.write_latch_flag = 1'b0;
      end
      if (page_ev) begin
        next_st.sweep = 1'b1;
        next_st.idx = '0;
      end
      if (wsr_ev) begin
        next_st.block_protect_low = st.wsr[ST_BP_LOW_BIT];
        next_st.block_protect_high = st.wsr[ST_BP_HIGH_BIT];
        next_st.hw_protect_enable = st.wsr[ST_HWP_BIT];
      end
      next_st.state = S_IDLE;
      next_st.pend_set = 1'b0;
      next_st.pend_clr = 1'b0;
    end else if (cs_fall) begin
      next_st.state = S_OPC;
      next_st.bitcnt = '0;
    end else if (sck_rise && st.state != S_IGNORE && st.state != S_IDLE) begin
      next_st.in_sr = in_byte;
      next_st.bitcnt = st.bitcnt + 3'h1;
      if (st.bitcnt == 3'h7) begin
        unique case (st.state)
          S_OPC: begin
            if (prog.busy && in_byte != OPC_RD_STATUS) begin
              next_st.state = S_IGNORE;
            end else begin
              unique case (in_byte)
                OPC_SET_LATCH: begin
                  next_st.state = S_WAITCS;
                  next_st.pend_set = 1'b1;
                end
                OPC_CLR_LATCH: begin
                  next_st.state = S_WAITCS;
                  next_st.pend_clr = 1'b1;
                end
                OPC_RD_STATUS: next_st.state = S_RSTAT;
                OPC_WR_STATUS: begin
                  next_st.state = S_WSTAT;
                  next_st.wsr_ok = 1'b0;
                end
                OPC_RD_MEM: begin
                  next_st.state = S_ADDR_HI;
                  next_st.is_wr = 1'b0;
                end
                OPC_WR_MEM: begin
                  next_st.state = S_ADDR_HI;
                  next_st.is_wr = 1'b1;
                  next_st.pvalid = '0;
                end
                default: next_st.state = S_IGNORE;
              endcase
            end
          end
          S_ADDR_HI: begin
            next_st.addr[ADDR_W-1:8] = in_byte[ADDR_W-9:0];
            next_st.state = S_ADDR_LO;
          end
          S_ADDR_LO: begin
            next_st.addr[7:0] = in_byte;
            next_st.state = st.is_wr ? S_WDATA : S_RDATA;
          end
          S_RDATA: next_st.addr = st.addr + ADDR_W'(1);
          S_WDATA: begin
            next_st.pbuf[st.addr[PAGE_W-1:0]] = in_byte;
            next_st.pvalid[st.addr[PAGE_W-1:0]] = 1'b1;
            next_st.addr[PAGE_W-1:0] = st.addr[PAGE_W-1:0] + PAGE_W'(1);
          end
          S_WSTAT: begin
            next_st.wsr = in_byte;
            next_st.wsr_ok = 1'b1;
          end
          S_RSTAT, S_WAITCS, S_IGNORE, S_IDLE: begin
          end
        endcase
      end
    end else if (sck_fall && (st.state == S_RDATA || st.state == S_RSTAT)) begin
      if (st.bitcnt == 3'h0) begin
        // Status is re-sampled at every byte so busy can be polled in one frame
        next_st.out_sr = (st.state == S_RSTAT) ? status_val : mem_rdata;
        next_st.so = next_st.out_sr[7];
        next_st.out_sr = {next_st.out_sr[6:0], 1'b0};
      end else begin
        next_st.so = st.out_sr[7];
        next_st.out_sr = {st.out_sr[6:0], 1'b0};
      end
    end
    next_st.oe_n = !(next_st.state == S_RDATA || next_st.state == S_RSTAT);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.state <= S_IDLE;
      st.oe_n <= 1'b1;
      st.cs_d <= 1'b1;
      st.write_latch_flag <= 1'b0;
      st.block_protect_low <= BP_RST[0];
      st.block_protect_high <= BP_RST[1];
      st.hw_protect_enable <= HWP_EN_RST;
    end else begin
      st <= next_st;
    end
  end

  assign so = st.so;
  assign so_oe_n = st.oe_n;
  assign mem_addr = st.maddr;
  assign mem_wdata = st.mwdata;
  assign mem_we = st.mwe;
  assign status_protect_reg = status_val;

  chk_latch_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(st.write_latch_flag) |-> $past(set_ev))
    else $error("write latch set without set-latch frame");
  chk_latch_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(prog.busy) |=> !st.write_latch_flag)
    else $error("write latch survived write cycle");
  chk_start_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    prog.start |-> st.write_latch_flag)
    else $error("write started with latch clear");
  chk_we_protect: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_we |-> (!sepcp_is_prot(bp, mem_addr) && prog.busy))
    else $error("protected or idle array write");
  chk_busy_ignore: assert property (@(posedge mclk) disable iff (!rst_n)
    (prog.busy && sck_rise && st.state == S_OPC && st.bitcnt == 3'h7 && in_byte != OPC_RD_STATUS)
    |=> st.state == S_IGNORE)
    else $error("command obeyed while busy");
  chk_status_bits: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed({st.hw_protect_enable, bp}) |-> $past(wsr_ev))
    else $error("status bits changed without status write");
  chk_float_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (st.state == S_IGNORE || st.state == S_IDLE) |-> so_oe_n)
    else $error("output driven outside a read");
  chk_read_step: assert property (@(posedge mclk) disable iff (!rst_n)
    (sck_rise && st.state == S_RDATA && st.bitcnt == 3'h7) |=> st.addr == ADDR_W'($past(st.addr) + 1))
    else $error("read address did not step");
  chk_page_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
    (sck_rise && st.state == S_WDATA && st.bitcnt == 3'h7)
    |=> st.addr[ADDR_W-1:PAGE_W] == $past(st.addr[ADDR_W-1:PAGE_W]))
    else $error("page write left its page");
  // Checked on the stored bits, since the pin may lift protection in the very next cycle
  chk_hw_lock: assert property (@(posedge mclk) disable iff (!rst_n)
    hw_prot |=> $stable({st.hw_protect_enable, bp}))
    else $error("status write under hardware protect");
endmodule // sepcp_core

// ==== sepcp_pkg.sv ====
// Purpose: Shared constants and types for the SPI EEPROM command and protect block
// Assumes: 20 MHz mclk
// Notes: Status layout is protect-enable, three zero bits, two block bits, latch, busy
package sepcp_pkg;
  localparam logic [7:0] OPC_SET_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
  localparam logic [7:0] OPC_RD_STATUS = 8'h05;
  localparam logic [7:0] OPC_WR_STATUS = 8'h01;
  localparam logic [7:0] OPC_RD_MEM = 8'h03;
  localparam logic [7:0] OPC_WR_MEM = 8'h02;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_BP_LOW_BIT = 2;
  localparam int ST_BP_HIGH_BIT = 3;
  localparam int ST_HWP_BIT = 7;
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic HWP_EN_RST = 1'b0;
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 6;
  localparam int WRITE_TIME_US = 10000;
  localparam int CLK_KHZ = 20000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_KHZ / 1000;
  localparam int MIN_WRITE_CYCLES = (1 << PAGE_W) + 2;

  typedef enum logic [3:0] {
    S_IDLE, S_OPC, S_ADDR_HI, S_ADDR_LO, S_RDATA, S_RSTAT, S_WDATA, S_WSTAT, S_WAITCS, S_IGNORE
  } sepcp_state_t;

  function automatic logic sepcp_is_prot(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (bp)
      2'h0: hit = 1'b0;
      2'h1: hit = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
      2'h2: hit = a[ADDR_W-1];
      2'h3: hit = 1'b1;
    endcase
    return hit;
  endfunction
endpackage

// ==== sepcp_prog_if.sv ====
// Purpose: Start and busy pair between command core and write timer
// Assumes: Both ends on mclk
// Notes: Start is a one-cycle pulse
`timescale 1ns/1ps
interface sepcp_prog_if;
  logic start;
  logic busy;
  modport core (output start, input busy);
  modport timer (input start, output busy);
endinterface

// ==== sepcp_sync.sv ====
// Purpose: Three-flop pin synchroniser with agreement filter
// Assumes: Pin is asynchronous to mclk
// Notes: Level changes only when the second and third stages agree
`timescale 1ns/1ps
module sepcp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pin and result
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sepcp_sync_t;
  sepcp_sync_t st;
  sepcp_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.lvl = st.s3;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= {4{RST_VAL}};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;
endmodule // sepcp_sync

// ==== sepcp_wtimer.sv ====
// Purpose: Self-timed write cycle duration
// Assumes: Start is ignored while busy
// Notes: Shorten WRITE_CYCLES in simulation
`timescale 1ns/1ps
module sepcp_wtimer
  import sepcp_pkg::*;
#(
  parameter int WCYC = WRITE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Core side
  sepcp_prog_if.timer p
);
  localparam int CW = $clog2(WCYC + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
  } sepcp_tmr_t;
  sepcp_tmr_t st;
  sepcp_tmr_t next_st;

  always_comb begin
    next_st = st;
    if (p.start && st.cnt == '0) begin
      next_st.cnt = CW'(WCYC);
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign p.busy = (st.cnt != '0);

  chk_busy_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(p.busy) |-> p.busy [*8])
    else $error("busy dropped early");
  chk_busy_start: assert property (@(posedge mclk) disable iff (!rst_n)
    (p.start && !p.busy) |=> p.busy)
    else $error("start did not raise busy");
endmodule // sepcp_wtimer

// ==== sepcp_array_model.sv ====
// Purpose: Behavioural array behind the command core
// Assumes: Read is combinational, write on the strobe
// Notes: Preloaded with the low address byte so untouched cells are known
`timescale 1ns/1ps
module sepcp_array_model
  import sepcp_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Array port
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  output logic [7:0] mem_rdata
);
  logic [7:0] cells [0:(1<<ADDR_W)-1];
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      cells[i] = i[7:0];
    end
  end
  always @(posedge mclk) begin
    if (mem_we) begin
      cells[mem_addr] <= mem_wdata;
    end
  end
  assign mem_rdata = cells[mem_addr];
endmodule // sepcp_array_model

// ==== spi_eeprom_command_protect_test.sv ====
// Purpose: Self-checking bench for the SPI EEPROM command and protect block
// Assumes: sck period 400 ns, write time shortened to 600 mclk
// Notes: Host pins change 2 ns after mclk rises; so is sampled just before sck falls
`timescale 1ns/1ps
module spi_eeprom_command_protect_test;
  import sepcp_pkg::*;
  localparam int WC = 600;
  logic mclk, rst_n, cs_n, sck, si, wp_n, so, so_oe_n, mem_we, oe_last;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, status_protect_reg;
  logic [7:0] rx[$];
  logic [7:0] pq[$];
  logic [15:0] pa[3] = '{16'h6000, 16'h4000, 16'h0000};
  int n_mismatch, compares, cyc;

  sepcp_core #(.WCYC(WC)) dut (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .so(so), .so_oe_n(so_oe_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_rdata(mem_rdata), .status_protect_reg(status_protect_reg));
  sepcp_array_model arr (.mclk(mclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_rdata(mem_rdata));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and still reaches the verdict
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bits go out MSB first, si changes only while sck is low
  task automatic xb(input logic [7:0] d, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i >= 8 - n; i--) begin
      si = d[i];
      tick(4);
      sck = 1'b1;
      tick(4);
      // A floating output reads as the inverse of its last value
      r[i] = so_oe_n ? ~so : so;
      sck = 1'b0;
    end
  endtask

  // Whole bytes, then tail stray bits; select rises with sck low
  task automatic frame(input logic [7:0] b[$], input int tail);
    logic [7:0] r;
    rx = {};
    cs_n = 1'b0;
    tick(4);
    foreach (b[k]) begin
      xb(b[k], 8, r);
      rx.push_back(r);
    end
    xb(8'hff, tail, r);
    oe_last = so_oe_n;
    tick(4);
    cs_n = 1'b1;
    tick(8);
    check("so released", so_oe_n, 1'b1);
  endtask

  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (status_protect_reg[ST_BUSY_BIT] !== 1'b0 && n < lim) begin
      tick(1);
      n++;
    end
    check("ready", status_protect_reg[ST_BUSY_BIT], 1'b0);
    // The latch clears one cycle after busy falls
    tick(2);
  endtask

  task automatic write_status_cmd(input logic [7:0] v);
    frame({OPC_SET_LATCH}, 0);
    frame({OPC_WR_STATUS, v}, 0);
    wait_ready(WC + 50);
  endtask

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    wp_n = 1'b1;
    rst_n = 1'b0;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    tick(8);
    rst_n = 1'b1;
    tick(8);
    check("status reset", status_protect_reg, 8'h00);
    check("so reset", so_oe_n, 1'b1);
    frame({OPC_WR_MEM, 8'h00, 8'h10, 8'hc3}, 0);
    check("no latch write", status_protect_reg, 8'h00);
    check("no latch cell", arr.cells[15'h0010], 8'h10);
    frame({OPC_SET_LATCH, OPC_WR_MEM, 8'h00, 8'h11, 8'hc3}, 0);
    check("same frame busy", status_protect_reg[ST_BUSY_BIT], 1'b0);
    check("same frame cell", arr.cells[15'h0011], 8'h11);
    frame({OPC_SET_LATCH}, 0);
    check("latch set", status_protect_reg, 8'h02);
    frame({OPC_CLR_LATCH}, 0);
    check("latch clear", status_protect_reg, 8'h00);
    // Byte write at the top cell, address MSB set and ignored
    frame({OPC_SET_LATCH}, 0);
    frame({OPC_WR_MEM, 8'hff, 8'hff, 8'ha5}, 0);
    check("busy set", status_protect_reg[ST_BUSY_BIT], 1'b1);
    frame({OPC_RD_STATUS, 8'h00}, 0);
    check("status read busy", rx[1], 8'h03);
    frame({OPC_WR_MEM, 8'h00, 8'h20, 8'h77}, 0);
    wait_ready(WC);
    check("latch auto clear", status_protect_reg, 8'h00);
    check("ignored write", arr.cells[15'h0020], 8'h20);
    check("byte written", arr.cells[15'h7fff], 8'ha5);
    frame({OPC_RD_MEM, 8'hff, 8'hff, 8'h00, 8'h00}, 0);
    check("read top", rx[3], 8'ha5);
    check("read wrap", rx[4], 8'h00);
    // Page write of 66 bytes wraps onto the page start
    frame({OPC_SET_LATCH}, 0);
    pq = {OPC_WR_MEM, 8'h01, 8'h40};
    for (int k = 0; k < 66; k++) begin
      pq.push_back(k[7:0]);
    end
    frame(pq, 0);
    tick(WC - 100);
    check("busy held", status_protect_reg[ST_BUSY_BIT], 1'b1);
    wait_ready(150);
    check("page wrap 0", arr.cells[15'h0140], 8'h40);
    check("page wrap 1", arr.cells[15'h0141], 8'h41);
    check("page mid", arr.cells[15'h0142], 8'h02);
    check("page end", arr.cells[15'h017f], 8'h3f);
    check("next page", arr.cells[15'h0180], 8'h80);
    // Each block-protect level guards its lowest protected cell
    for (int b = 1; b < 4; b++) begin
      write_status_cmd({4'h0, b[1:0], 2'h0});
      check("block bits", status_protect_reg, {4'h0, b[1:0], 2'h0});
      frame({OPC_SET_LATCH}, 0);
      frame({OPC_WR_MEM, pa[b-1][15:8], pa[b-1][7:0], 8'hee}, 0);
      wait_ready(WC + 50);
      check("protected cell", arr.cells[pa[b-1][14:0]], 8'h00);
    end
    write_status_cmd(8'hff);
    check("writable bits", status_protect_reg, 8'h8c);
    wp_n = 1'b0;
    write_status_cmd(8'h00);
    check("hw protect", status_protect_reg, 8'h8e);
    wp_n = 1'b1;
    write_status_cmd(8'h00);
    check("hw released", status_protect_reg, 8'h00);
    frame({8'hff, 8'h00}, 0);
    check("bad opcode float", oe_last, 1'b1);
    frame({OPC_SET_LATCH}, 0);
    frame({OPC_WR_MEM, 8'h00, 8'h30, 8'h55}, 4);
    check("split write", status_protect_reg, 8'h02);
    check("split cell", arr.cells[15'h0030], 8'h30);
    give_verdict();
  end
endmodule // spi_eeprom_command_protect_test
